// File: core/psp_defines.svh
// Constants for the partner supervision and panel logic
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// ====
// Register byte offsets
`define PSP_OFS_CTRL      12'h000
`define PSP_OFS_STATUS    12'h004
`define PSP_OFS_LINE      12'h008
`define PSP_OFS_PARAM     12'h00c
`define PSP_OFS_PANEL     12'h010

// ====
// Control register fields
`define PSP_CTRL_DIRECT_BURNER  0
`define PSP_CTRL_CURVE_BY_LINES 1
`define PSP_CTRL_INACTIVE_OK    2

// ====
// Line ranges and codes
`define PSP_LINE_FIRST     8'd1
`define PSP_LINE_USER_LAST 8'd50
`define PSP_LINE_LAST      8'd197
`define PSP_BLOCK_SIZE     8'd10
`define PSP_VALUE_MAX      16'h7ffe
`define PSP_VALUE_DASHED   16'hffff
`define PSP_ERR_NO_PARTNER 8'd142
`define PSP_ERR_DUP_ADDR   8'd82
`define PSP_MISS_LIMIT     2'd3

// ====
// Timing
`define PSP_CLK_HZ         20000000
`define PSP_TICK_MS        100
`define PSP_TICK_CYCLES    ((`PSP_CLK_HZ / 1000) * `PSP_TICK_MS)
`define PSP_ACTIVE_MIN     10
`define PSP_RETRY_MIN      1
`define PSP_TICKS_PER_MIN  (60000 / `PSP_TICK_MS)
`define PSP_HOLD_S         3
`define PSP_HOLD_TICKS     ((`PSP_HOLD_S * 1000) / `PSP_TICK_MS)

`endif

// File: core/psp_pkg.sv
// Types shared by the partner supervision and panel logic
package psp_pkg;

  // ====
  // Supervision states, one-hot
  typedef enum logic [2:0]
  {
    PSP_ST_WAIT  = 3'b001,
    PSP_ST_QUERY = 3'b010,
    PSP_ST_REPLY = 3'b100
  } psp_sup_e;

  // Info display selections
  typedef enum logic [1:0]
  {
    PSP_INFO_FLOW    = 2'd0,
    PSP_INFO_ROOM    = 2'd1,
    PSP_INFO_OUTSIDE = 2'd2,
    PSP_INFO_TIME    = 2'd3
  } psp_info_e;

endpackage

// File: core/psp_tick.sv
// Slow time-base tick divider
`timescale 1ns/1ns
`include "psp_defines.svh"
module psp_tick
  import psp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PSP_TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  // Tick out
  output logic      tick
);

  logic [31:0] cnt_q;

  // ====
  // Divider, cleared at power-up
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end
    else if (ce)
    begin
      tick <= (cnt_q == 32'(TICK_CYCLES - 1));
      if (cnt_q == 32'(TICK_CYCLES - 1))
        cnt_q <= 32'h0;
      else
        cnt_q <= cnt_q + 32'h1;
    end
  end

endmodule

// File: core/psp_edge.sv
// Press detector for a group of synchronous buttons
`timescale 1ns/1ns
module psp_edge
  import psp_pkg::*;
#(
  parameter int unsigned N = 12
)
(
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  // Buttons
  input  wire logic [N-1:0] level,
  output logic      [N-1:0] press
);

  logic [N-1:0] prev_q;

  // ====
  // Two registers per button
  for (genvar i = 0; i < N; i++)
  begin : g_btn
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        prev_q[i] <= 1'b0;
        press[i]  <= 1'b0;
      end
      else if (ce)
      begin
        prev_q[i] <= level[i];
        press[i]  <= level[i] & ~prev_q[i];
      end
    end
  end

endmodule

// File: core/psp_top.sv
// Partner supervision and front-panel logic of a second-circuit controller
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "psp_defines.svh"

// Notes on behaviour
// RULE1: Periodic partner query; good reply: active, requery in 10 min.
// RULE2: Inadmissible partner: passive, requery in 1 min.
// RULE3: No reply keeps status, requery in 1 min; third miss: passive.
// RULE4: Power-up passive; only good identification leaves it.
// RULE5: Passive: pump off, mixing valve closed.
// RULE6: Passive raises fault, missing-partner code.
// RULE7: Passive keeps manual, panel, room unit and bus working. Code still forces the valve closed, manual included, while passive.
// RULE8: Four mode buttons; press selects mode, only its LED lit.
// RULE9: Curve set by lines: sliders ignored.
// RULE10: Manual button toggles manual with LED; mode press leaves it.
// RULE11: In manual, open/close held drives valve, its LED lit.
// RULE12: Burner plants: manual close press toggles burner stage two.
// RULE13: Pump LED lit exactly while pump output on.
// RULE14: Line buttons step line down or up by one.
// RULE15: Minus and plus step displayed value down and up.
// RULE16: Edit committed only on info or mode press.
// RULE17: Stepping past end gives dashed code, which then sticks.
// RULE18: Button combinations jump to next higher or lower block.
// RULE19: Info press steps flow, room, outside, time; last stays. Code wraps from time back to flow.
// RULE20: Without engineer access only lines 1 to 50.
// RULE21: Both line buttons held 3 s open all lines.
// RULE22: Duplicate address: its code, held passive.
// RULE23: Installer numbers device one below partner, same segment.
// RULE24: Intervals and hold counted from slow tick, cleared at power-up.
module psp_top
  import psp_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PSP_TICK_CYCLES
)
(
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Process bus partner query
  output logic             query_req,
  input  wire logic        reply_valid,
  input  wire logic        reply_none,
  input  wire logic        reply_admissible,
  input  wire logic        dup_address,
  // Buttons
  input  wire logic [3:0]  btn_mode,
  input  wire logic        btn_manual,
  input  wire logic        btn_open,
  input  wire logic        btn_close,
  input  wire logic        btn_line_dn,
  input  wire logic        btn_line_up,
  input  wire logic        btn_minus,
  input  wire logic        btn_plus,
  input  wire logic        btn_info,
  // Heating curve sliders and controller demands
  input  wire logic [7:0]  slider_hot,
  input  wire logic [7:0]  slider_mild,
  input  wire logic        ctl_pump,
  input  wire logic        ctl_open,
  input  wire logic        ctl_close,
  // Outputs
  output logic             heating_pump_output,
  output logic             mixing_valve_output_open,
  output logic             mixing_valve_output_close,
  output logic             burner_stage2,
  output logic             active_mode,
  output logic             fault,
  output logic [7:0]       error_code,
  output logic [3:0]       led_mode,
  output logic             led_manual,
  output logic             led_open,
  output logic             led_close,
  output logic             led_pump,
  output logic [7:0]       curve_hot,
  output logic [7:0]       curve_mild,
  output logic [1:0]       info_sel,
  output logic [7:0]       line_num,
  output logic [15:0]      disp_value,
  output logic             engineer
);

  // ====
  // Time base and button presses
  logic        tick;
  logic [11:0] press;
  logic [11:0] lvl;

  assign lvl = {btn_info, btn_plus, btn_minus, btn_line_up, btn_line_dn,
                btn_close, btn_open, btn_manual, btn_mode};

  psp_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .tick    (tick)
  );

  psp_edge #(.N(12)) u_edge
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .level   (lvl),
    .press   (press)
  );

  logic       p_manual, p_close, p_dn, p_up, p_minus, p_plus, p_info, any_mode;
  assign any_mode = |press[3:0];
  assign p_manual = press[4];
  assign p_close  = press[6];
  assign p_dn     = press[7];
  assign p_up     = press[8];
  assign p_minus  = press[9];
  assign p_plus   = press[10];
  assign p_info   = press[11];

  // ====
  // Software registers
  logic [2:0]  ctrl_q;
  logic [15:0] param_q;

  // ====
  // Partner supervision
  psp_sup_e    st_q;
  logic [15:0] wait_q;
  logic [1:0]  miss_q;

  // Query scheduler and mode decision
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q        <= PSP_ST_QUERY;
      wait_q      <= 16'h0;
      miss_q      <= 2'd0;
      active_mode <= 1'b0;                    // see RULE4
      query_req   <= 1'b0;
    end
    else if (ce)
    begin
      query_req <= 1'b0;
      unique case (st_q)
        PSP_ST_QUERY:
        begin
          query_req <= 1'b1;                  // see RULE1
          st_q      <= PSP_ST_REPLY;
        end
        PSP_ST_REPLY:
          if (reply_valid)
          begin
            st_q <= PSP_ST_WAIT;
            if (reply_none)
            begin
              // Status kept until the third miss in a row
              wait_q <= 16'(`PSP_RETRY_MIN * `PSP_TICKS_PER_MIN);  // see RULE3
              if (miss_q == `PSP_MISS_LIMIT - 2'd1)
                active_mode <= 1'b0;          // see RULE3
              else
                miss_q <= miss_q + 2'd1;
            end
            else if (reply_admissible && !dup_address)
            begin
              miss_q      <= 2'd0;
              active_mode <= 1'b1;            // see RULE1
              wait_q      <= 16'(`PSP_ACTIVE_MIN * `PSP_TICKS_PER_MIN);
            end
            else
            begin
              miss_q      <= 2'd0;
              active_mode <= 1'b0;            // see RULE2
              wait_q      <= 16'(`PSP_RETRY_MIN * `PSP_TICKS_PER_MIN);
            end
          end
        PSP_ST_WAIT:
          if (tick)
          begin
            if (wait_q <= 16'h1)
              st_q <= PSP_ST_QUERY;           // see RULE24
            else
              wait_q <= wait_q - 16'h1;
          end
        default:
          st_q <= PSP_ST_QUERY;
      endcase
      // Duplicate address holds passive until corrected
      if (dup_address)
        active_mode <= 1'b0;                  // see RULE22
    end
  end

  // Fault report
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault      <= 1'b1;
      error_code <= `PSP_ERR_NO_PARTNER;
    end
    else if (ce)
    begin
      fault <= dup_address | ~active_mode;    // see RULE6
      if (dup_address)
        error_code <= `PSP_ERR_DUP_ADDR;      // see RULE22
      else if (!active_mode)
        error_code <= `PSP_ERR_NO_PARTNER;    // see RULE6
      else
        error_code <= 8'h0;
    end
  end

  // ====
  // Modes and manual; panel works in passive (see RULE7)
  logic manual_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      led_mode      <= 4'b0001;
      manual_q      <= 1'b0;
      burner_stage2 <= 1'b0;
    end
    else if (ce)
    begin
      if (any_mode)
        led_mode <= press[3:0] & (~press[3:0] + 4'd1);   // see RULE8
      if (any_mode)
        manual_q <= 1'b0;                     // see RULE10
      else if (p_manual)
        manual_q <= ~manual_q;                // see RULE10
      if (manual_q && ctrl_q[`PSP_CTRL_DIRECT_BURNER] && p_close)
        burner_stage2 <= ~burner_stage2;      // see RULE12
    end
  end

  // Outputs; passive forces pump off and valve closing
  logic man_open, man_close;
  assign man_open  = manual_q & btn_open & ~btn_close;
  assign man_close = manual_q & btn_close & ~btn_open
                     & ~ctrl_q[`PSP_CTRL_DIRECT_BURNER];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      heating_pump_output       <= 1'b0;
      mixing_valve_output_open  <= 1'b0;
      mixing_valve_output_close <= 1'b0;
      led_pump                  <= 1'b0;
      led_manual                <= 1'b0;
      led_open                  <= 1'b0;
      led_close                 <= 1'b0;
    end
    else if (ce)
    begin
      heating_pump_output <= active_mode & ctl_pump;  // see RULE5
      led_pump            <= active_mode & ctl_pump;  // see RULE13
      if (manual_q)
      begin
        mixing_valve_output_open  <= man_open & active_mode;             // see RULE11
        mixing_valve_output_close <= man_close | ~active_mode;           // see RULE5
      end
      else
      begin
        mixing_valve_output_open  <= ctl_open & ~ctl_close & active_mode;
        mixing_valve_output_close <= (ctl_close & ~ctl_open) | ~active_mode;
      end
      led_manual <= manual_q;                 // see RULE10
      led_open   <= man_open;                 // see RULE11
      led_close  <= manual_q & btn_close;
    end
  end

  // Heating curve: sliders followed unless set by lines
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      curve_hot  <= 8'h0;
      curve_mild <= 8'h0;
    end
    else if (ce && !ctrl_q[`PSP_CTRL_CURVE_BY_LINES])
    begin
      curve_hot  <= slider_hot;               // see RULE9
      curve_mild <= slider_mild;
    end
  end

  // ====
  // Info selection, stepped on each press, wraps from time back to flow
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      info_sel <= PSP_INFO_FLOW;
    else if (ce && p_info)
      info_sel <= info_sel + 2'd1;            // see RULE19
  end

  // ====
  // Engineer access
  logic [7:0] hold_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_q   <= 8'h0;
      engineer <= 1'b0;
    end
    else if (ce)
    begin
      if (!(btn_line_dn && btn_line_up))
        hold_q <= 8'h0;
      else if (tick && hold_q != 8'(`PSP_HOLD_TICKS))
        hold_q <= hold_q + 8'h1;              // see RULE24
      if (hold_q == 8'(`PSP_HOLD_TICKS))
        engineer <= 1'b1;                     // see RULE21
    end
  end

  // ====
  // Line navigation; combos are a line button held with a setting press
  logic [7:0] top_line;
  assign top_line = engineer ? `PSP_LINE_LAST : `PSP_LINE_USER_LAST;  // see RULE20

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      line_num <= `PSP_LINE_FIRST;
    else if (ce)
    begin
      if (btn_line_up && p_plus)
        line_num <= (line_num + `PSP_BLOCK_SIZE > top_line) ? top_line
                    : line_num + `PSP_BLOCK_SIZE;                   // see RULE18
      else if (btn_line_dn && p_minus)
        line_num <= (line_num <= `PSP_BLOCK_SIZE) ? `PSP_LINE_FIRST
                    : line_num - `PSP_BLOCK_SIZE;                   // see RULE18
      else if (p_up && !btn_line_dn && line_num < top_line)
        line_num <= line_num + 8'd1;          // see RULE14
      else if (p_dn && !btn_line_up && line_num > `PSP_LINE_FIRST)
        line_num <= line_num - 8'd1;          // see RULE14
      else if (line_num > top_line)
        line_num <= top_line;                 // see RULE20
    end
  end

  // Edited value and commit
  logic in_combo, line_move;
  assign in_combo  = btn_line_up | btn_line_dn;
  assign line_move = p_up | p_dn;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      disp_value <= 16'h0;
      param_q    <= 16'h0;
    end
    else if (ce)
    begin
      if (p_info || any_mode)
        param_q <= disp_value;                // see RULE16
      if (line_move)
        disp_value <= param_q;                // Uncommitted edit discarded
      else if (disp_value == `PSP_VALUE_DASHED)
        disp_value <= disp_value;             // see RULE17
      else if (p_plus && !in_combo)
      begin
        if (disp_value < `PSP_VALUE_MAX)
          disp_value <= disp_value + 16'h1;   // see RULE15
        else if (ctrl_q[`PSP_CTRL_INACTIVE_OK])
          disp_value <= `PSP_VALUE_DASHED;    // see RULE17
      end
      else if (p_minus && !in_combo)
      begin
        if (disp_value != 16'h0)
          disp_value <= disp_value - 16'h1;   // see RULE15
        else if (ctrl_q[`PSP_CTRL_INACTIVE_OK])
          disp_value <= `PSP_VALUE_DASHED;    // see RULE17
      end
    end
  end

  // ====
  // AXI4-Lite slave, one write and one read at a time
  logic        aw_hold_q, w_hold_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 12'h0;
      wdata_q       <= 32'h0;
      ctrl_q        <= 3'b000;
    end
    else if (ce)
    begin
      s_axi_awready <= ~aw_hold_q & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_q & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
      end
      if (aw_hold_q && w_hold_q && !s_axi_bvalid)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == `PSP_OFS_CTRL) ? 2'b00 : 2'b10;
        if (awaddr_q == `PSP_OFS_CTRL)
          ctrl_q <= wdata_q[2:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'b00;
    end
    else if (ce)
    begin
      s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        unique case (s_axi_araddr)
          `PSP_OFS_CTRL:   s_axi_rdata <= {29'h0, ctrl_q};
          `PSP_OFS_STATUS: s_axi_rdata <= {16'h0, error_code, 4'h0,
                                           engineer, manual_q, fault, active_mode};
          `PSP_OFS_LINE:   s_axi_rdata <= {22'h0, info_sel, line_num};
          `PSP_OFS_PARAM:  s_axi_rdata <= {disp_value, param_q};
          `PSP_OFS_PANEL:  s_axi_rdata <= {24'h0, led_mode, led_pump,
                                           led_close, led_open, led_manual};
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: test/psp_assertions.sv
// Concurrent checks on the partner supervision outputs
`timescale 1ns/1ns
module psp_assertions
#(
  parameter int unsigned TICK_CYCLES = 2
)
(
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Partner link
  input wire logic       query_req,
  input wire logic       reply_valid,
  input wire logic       reply_none,
  input wire logic       reply_admissible,
  input wire logic       dup_address,
  // Watched outputs
  input wire logic       active_mode,
  input wire logic       fault,
  input wire logic [7:0] error_code,
  input wire logic       heating_pump_output,
  input wire logic [3:0] led_mode
);
  // ==========
  // Helpers
  int unsigned gap_q;
  int unsigned per;
  logic [1:0]  miss_q;
  // Cycles since the last query
  always_ff @(posedge aclk)
    gap_q <= (!aresetn || query_req) ? 0 : gap_q + 1;
  // Silent replies in a row, saturating
  always_ff @(posedge aclk)
    if (!aresetn)
      miss_q <= 2'd0;
    else if (reply_valid)
      miss_q <= reply_none ? miss_q + {1'b0, miss_q != 2'd3} : 2'd0;
  // Long wait only after a good reply; slack covers tick phase and reply delay
  assign per = (active_mode && miss_q == 2'd0) ? 6000 * TICK_CYCLES : 600 * TICK_CYCLES;
  // ==========
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_passive;
    !active_mode ##1 !active_mode;
  endsequence
  a_reset_passive: assert property
    ($rose(aresetn) |-> !active_mode && fault && error_code == 8'd142)
    else $error("not passive after reset");
  a_good_active: assert property
    (reply_valid && !reply_none && reply_admissible && !dup_address |=> active_mode)
    else $error("good reply not active");
  a_bad_passive: assert property
    (reply_valid && !reply_none && !reply_admissible |=> !active_mode)
    else $error("wrong partner not passive");
  a_miss_hold: assert property
    (reply_valid && reply_none && miss_q < 2'd2 |=> $stable(active_mode))
    else $error("miss changed status");
  a_third_miss: assert property
    (reply_valid && reply_none && miss_q == 2'd2 |=> !active_mode)
    else $error("third miss not passive");
  a_query_gap: assert property
    (query_req && gap_q > 16 |-> gap_q + 12 > per && gap_q < per + 12)
    else $error("query spacing off");
  a_passive_safe: assert property
    (s_passive |-> !heating_pump_output)
    else $error("pump on while passive");
  a_mode_led: assert property
    ($onehot(led_mode))
    else $error("mode leds not one-hot");
  a_dup_passive: assert property
    (dup_address[*3] |-> !active_mode && error_code == 8'd82)
    else $error("duplicate address ignored");
endmodule
bind psp_top psp_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_checks (.*);

// File: test/psp_partner.sv
// Behavioural partner controller answering supervision queries
`timescale 1ns/1ns
module psp_partner
(
  // Clock and controls: kind 0 good, 1 wrong type, 2 silent
  input  wire logic       aclk,
  input  wire logic [1:0] kind,
  input  wire logic [3:0] delay,
  // Query and reply
  input  wire logic       query_req,
  output logic            reply_valid = 1'b0,
  output logic            reply_none = 1'b0,
  output logic            reply_admissible = 1'b0
);
  logic [3:0] wait_q = 4'h0;
  logic       pend_q = 1'b0;
  // Idle reply lines toggle, so a stale value never reads as an answer
  always_ff @(posedge aclk)
  begin
    reply_valid <= 1'b0;
    reply_none <= ~reply_none;
    reply_admissible <= ~reply_admissible;
    if (query_req)
    begin
      pend_q <= 1'b1;
      wait_q <= delay;
    end
    else if (wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
    else if (pend_q)
    begin
      pend_q <= 1'b0;
      reply_valid <= 1'b1;
      reply_none <= kind == 2'd2;
      reply_admissible <= kind == 2'd0;
    end
  end
endmodule

// File: test/psp_top_tb.sv
// Self-checking bench for the partner supervision and panel logic
`timescale 1ns/1ns
`include "psp_defines.svh"
module psp_top_tb;
  // ==========
  // Short tick: a minute is 1200 cycles
  localparam int unsigned TC = 2;
  localparam int MIN = 600 * TC;
  localparam int MAN = 4, OPN = 5, CLS = 6, DN = 7, UP = 8, MI = 9, PL = 10, INF = 11;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, dup_address = 1'b0, ctl_pump = 1'b1;
  logic        ctl_open = 1'b0, ctl_close = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0, b = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, d, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, delay = 4'h0, led_mode;
  logic [7:0]  slider_hot = 8'h33, slider_mild = 8'h22, error_code, curve_hot, curve_mild, line_num;
  logic [1:0]  kind = 2'd1, r, s_axi_bresp, s_axi_rresp, info_sel;
  logic [15:0] disp_value;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        query_req, reply_valid, reply_none, reply_admissible, heating_pump_output;
  logic        mixing_valve_output_open, mixing_valve_output_close, burner_stage2;
  logic        active_mode, fault, led_manual, led_open, led_close, led_pump, engineer;
  int          fail_count = 0, samples_checked = 0;
  // 50 ns clock
  always #25 aclk = ~aclk;
  psp_partner prt (.*);
  psp_top #(.TICK_CYCLES(TC)) dut
  (
    .btn_mode(b[3:0]), .btn_manual(b[4]), .btn_open(b[5]), .btn_close(b[6]),
    .btn_line_dn(b[7]), .btn_line_up(b[8]), .btn_minus(b[9]), .btn_plus(b[10]),
    .btn_info(b[11]), .*
  );
  // ==========
  // Tasks
  task automatic report_and_stop();
    $display("checked %0d, mismatched %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Bounded wait step; running out ends the run
  task automatic step(inout int n, input int lim);
    @(posedge aclk);
    n++;
    if (n > lim)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic press(input int i);
    @(posedge aclk);
    b[i] <= 1'b1;
    cyc(4);
    b[i] <= 1'b0;
    cyc(4);
  endtask
  task automatic wait_act(input logic v, input int lim);
    int n = 0;
    while (active_mode !== v) step(n, lim);
  endtask
  // AXI4-Lite write
  task automatic wr(input logic [11:0] a, input logic [31:0] w, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      step(n, 50);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [11:0] a);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do step(n, 50); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do step(n, 50); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // ==========
  // Main sequence
  initial
  begin
    cyc(4);
    aresetn <= 1'b1;
    rd(`PSP_OFS_STATUS);
    chk(d, {16'h0, `PSP_ERR_NO_PARTNER, 8'h02});
    rd(12'h100);
    chk({d[29:0], r}, 32'h2);
    wr(12'h100, 32'h5, 2'b10);
    $display("power-up done");
    for (int i = 0; i < 4; i++)
    begin
      press(i);
      chk(32'(led_mode), 32'h1 << i);
    end
    chk({30'h0, heating_pump_output, led_pump}, 32'h0);
    kind <= 2'd0;
    wait_act(1'b1, MIN + 64);
    rd(`PSP_OFS_STATUS);
    chk(d, 32'h1);
    chk({30'h0, heating_pump_output, led_pump}, 32'h3);
    wr(`PSP_OFS_CTRL, 32'h2, 2'b00);
    slider_hot <= 8'h44;
    rd(`PSP_OFS_CTRL);
    chk({d[15:0], curve_hot, curve_mild}, 32'h2_3322);
    $display("partner done");
    press(MAN);
    b[OPN] <= 1'b1;
    cyc(4);
    chk({29'h0, led_manual, mixing_valve_output_open, led_open}, 32'h7);
    b[OPN] <= 1'b0;
    press(0);
    chk({29'h0, led_manual, mixing_valve_output_open, led_open}, 32'h0);
    wr(`PSP_OFS_CTRL, 32'h3, 2'b00);
    press(MAN);
    press(CLS);
    chk(32'(burner_stage2), 32'h1);
    press(CLS);
    chk(32'(burner_stage2), 32'h0);
    press(1);
    chk({27'h0, led_manual, led_mode}, 32'h2);
    $display("manual done");
    press(PL);
    rd(`PSP_OFS_PARAM);
    chk(d, 32'h0001_0000);
    press(INF);
    rd(`PSP_OFS_PARAM);
    chk(d, 32'h0001_0001);
    press(INF);
    press(INF);
    chk(32'(info_sel), 32'h3);
    wr(`PSP_OFS_CTRL, 32'h6, 2'b00);
    press(MI);
    chk(32'(disp_value), 32'h0);
    press(MI);
    press(PL);
    chk(32'(disp_value), 32'(`PSP_VALUE_DASHED));
    $display("values done");
    repeat (60) press(UP);
    chk(32'(line_num), 32'(`PSP_LINE_USER_LAST));
    b[DN] <= 1'b1;
    cyc(2);
    b[UP] <= 1'b1;
    cyc(`PSP_HOLD_TICKS * TC + 20);
    b <= 12'h0;
    repeat (3) press(UP);
    chk({23'h0, engineer, line_num}, 32'h134);
    b[UP] <= 1'b1;
    press(PL);
    b <= 12'h0;
    cyc(4);
    chk(32'(line_num), 32'h3f);
    b[DN] <= 1'b1;
    press(MI);
    b <= 12'h0;
    cyc(4);
    chk(32'(line_num), 32'h34);
    $display("lines done");
    kind <= 2'd2;
    delay <= 4'h6;
    wait_act(1'b0, 12 * MIN + 200);
    rd(`PSP_OFS_STATUS);
    chk(d, {16'h0, `PSP_ERR_NO_PARTNER, 8'h0a});
    chk({30'h0, heating_pump_output, mixing_valve_output_close}, 32'h1);
    kind <= 2'd0;
    wait_act(1'b1, MIN + 64);
    dup_address <= 1'b1;
    cyc(4);
    chk({23'h0, active_mode, error_code}, 32'(`PSP_ERR_DUP_ADDR));
    $display("supervision done");
    report_and_stop();
  end
endmodule
